// *** ulbv_pkg.sv ***
`default_nettype none
package ulbv_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFF_OTG_CTRL  = 8'h04;
  localparam logic [7:0] OFF_PWR_CTRL  = 8'h08;
  localparam logic [7:0] OFF_PWM_RATE  = 8'h0c;
  localparam logic [7:0] OFF_PWM_CTRL  = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  // Main control fields
  localparam int MAIN_ATTACH_BIT = 0;
  localparam int MAIN_HOST_BIT   = 3;
  localparam int MAIN_SUSP_BIT   = 1;
  // OTG control fields
  localparam int OTG_DISCHG_BIT  = 0;
  localparam int OTG_TARGET_BIT  = 1;
  localparam int OTG_OVR_BIT     = 2;
  localparam int OTG_GEN_BIT     = 3;
  localparam int OTG_DMPD_BIT    = 4;
  localparam int OTG_DPPD_BIT    = 5;
  localparam int OTG_DPPU_BIT    = 7;
  // Power control fields
  localparam int PWR_ON_BIT      = 0;
  // PWM rate fields
  localparam int RATE_PER_LSB    = 0;
  localparam int RATE_DUTY_LSB   = 8;
  localparam int RATE_W          = 8;
  // PWM control fields
  localparam int PWMC_CNT_BIT    = 8;
  localparam int PWMC_POL_BIT    = 9;
  localparam int PWMC_ON_BIT     = 15;
  // Writable masks and reset values
  localparam logic [15:0] MAIN_MASK  = 16'h000b;
  localparam logic [15:0] OTG_MASK   = 16'h00bf;
  localparam logic [15:0] PWR_MASK   = 16'h0001;
  localparam logic [15:0] RATE_MASK  = 16'hffff;
  localparam logic [15:0] PWMC_MASK  = 16'h8300;
  localparam logic [15:0] REG_RESET  = 16'h0000;
endpackage
`default_nettype wire

// *** ulbv_pwm.sv ***
`default_nettype none
module ulbv_pwm #(
  parameter int W = 8
) (
  input  wire logic         clk_i,    // System clock
  input  wire logic         rst_n_i,  // Sync reset, active low
  input  wire logic         run_i,    // Counter enable
  input  wire logic         on_i,     // Output stage enable
  input  wire logic         pol_i,    // Output inversion
  input  wire logic [W-1:0] period_i, // Wrap value
  input  wire logic [W-1:0] duty_i,   // Active count
  output logic              pwm_o,    // Registered drive
  output logic [W-1:0]      count_o   // Current count
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  wire          wrap   = (cnt >= period_i);
  wire          active = (cnt < duty_i);
  // Count wraps at period; held while not running
  assign next_cnt = !run_i ? cnt : (wrap ? '0 : W'(cnt + 1'b1));
  // Count register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end
  // Output idles low when stage off, whatever the polarity; stage enable applied last
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= on_i & (active ^ pol_i);
  end
  assign count_o = cnt;

  a_cnt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !run_i |=> $stable(cnt)) else $error("pwm counter moved while stopped");
  a_cnt_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    run_i && cnt >= period_i |=> cnt == '0) else $error("pwm counter missed wrap");
  a_out_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !on_i |=> !pwm_o) else $error("pwm output active while stage off");
  a_out_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    on_i |=> pwm_o == (($past(cnt) < $past(duty_i)) ^ $past(pol_i)))
    else $error("pwm level wrong for count duty and polarity");
endmodule
`default_nettype wire

// *** ulbv_supply_model.sv ***
`default_nettype none
module ulbv_supply_model (
  input  wire logic clk_i,       // System clock
  input  wire logic rst_n_i,     // Sync reset, active low
  input  wire logic pwm_i,       // Boost switch drive
  input  wire logic gen_i,       // Generation enable
  input  wire logic fault_i,     // Load short from bench
  input  wire logic host_vbus_i, // Far host drives VBUS
  output logic      vbus_ok_o,   // Output within range
  output logic      over_curr_o  // Current limit reached
);
  logic [3:0] pulses;

  // Output rises only after three clocks of high switch drive or while host_vbus_i is high; low drive never clears the count, only reset or gen_i low
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !gen_i)
      pulses <= 4'h0;
    else if (pwm_i && pulses != 4'hf)
      pulses <= pulses + 4'h1;
  end

  // Comparator levels seen by the block; a host-driven bus also reads good
  assign vbus_ok_o   = (pulses >= 4'h3) | host_vbus_i;
  assign over_curr_o = fault_i & gen_i;
endmodule
`default_nettype wire

// *** ulbv_top.sv ***
// What this block does
// - With attach enable set, the D+ pull-up engages for a full-speed device.
// - With OTG override set, the D+ pull-up follows its override bit instead.
// - Host role select engages the D+ and D- pull-downs together.
// - With OTG override set, each pull-down follows its own override bit.
// - Suspend never releases the selected pull-up.
// - PWM control bit 9 selects output polarity.
// - OTG control bit 1 selects the VBUS target voltage.
// - The PWM counter runs only while counter enable is one.
// - The PWM output stage is active only while PWM enable is one.
// - OTG control bit 3 last of all starts VBUS generation.
// - The PWM output drives the external supply; comparators watch it.
//
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none
module ulbv_top (
  input  wire logic        clk_i,         // 50 MHz system clock
  input  wire logic        rst_n_i,       // Sync reset, active low
  input  wire logic        psel_i,        // APB select
  input  wire logic        penable_i,     // APB access phase
  input  wire logic        pwrite_i,      // APB write
  input  wire logic [7:0]  paddr_i,       // APB byte address
  input  wire logic [31:0] pwdata_i,      // APB write data
  output logic [31:0]      prdata_o,      // APB read data
  output logic             pready_o,      // APB ready
  output logic             pslverr_o,     // APB error on unmapped
  input  wire logic        vbus_ok_i,     // Comparator: VBUS in range
  input  wire logic        over_curr_i,   // Comparator: current limit hit
  output logic             dp_pullup_o,   // D+ pull-up enable
  output logic             dp_pulldown_o, // D+ pull-down enable
  output logic             dm_pulldown_o, // D- pull-down enable
  output logic             boost_pwm_o,   // Boost switch drive
  output logic             vbus_gen_o,    // VBUS generation enable
  output logic             vbus_target_o, // Target voltage select
  output logic             vbus_dischg_o  // VBUS discharge enable
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] port_main_control;
  logic [15:0] otg_control;
  logic [15:0] port_power_control;
  logic [15:0] boost_pwm_rate;
  logic [15:0] boost_pwm_control;
  logic [7:0]  pwm_count;

  // Address decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire acc      = psel_i & penable_i;
  wire wr       = acc & pwrite_i;
  wire sel_main = hit(paddr_i, ulbv_pkg::OFF_MAIN_CTRL);
  wire sel_otg  = hit(paddr_i, ulbv_pkg::OFF_OTG_CTRL);
  wire sel_pwr  = hit(paddr_i, ulbv_pkg::OFF_PWR_CTRL);
  wire sel_rate = hit(paddr_i, ulbv_pkg::OFF_PWM_RATE);
  wire sel_pwmc = hit(paddr_i, ulbv_pkg::OFF_PWM_CTRL);
  wire sel_stat = hit(paddr_i, ulbv_pkg::OFF_STATUS);
  wire mapped   = sel_main | sel_otg | sel_pwr | sel_rate | sel_pwmc | sel_stat;

  // Zero-wait slave; error only for unmapped addresses
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // Register writes take effect at the access edge only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      port_main_control  <= ulbv_pkg::REG_RESET;
      otg_control        <= ulbv_pkg::REG_RESET;
      port_power_control <= ulbv_pkg::REG_RESET;
      boost_pwm_rate     <= ulbv_pkg::REG_RESET;
      boost_pwm_control  <= ulbv_pkg::REG_RESET;
    end
    else if (wr)
    begin
      if (sel_main)
        port_main_control <= pwdata_i[15:0] & ulbv_pkg::MAIN_MASK;
      if (sel_otg)
        otg_control <= pwdata_i[15:0] & ulbv_pkg::OTG_MASK;
      if (sel_pwr)
        port_power_control <= pwdata_i[15:0] & ulbv_pkg::PWR_MASK;
      if (sel_rate)
        boost_pwm_rate <= pwdata_i[15:0] & ulbv_pkg::RATE_MASK;
      if (sel_pwmc)
        boost_pwm_control <= pwdata_i[15:0] & ulbv_pkg::PWMC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field extraction
  wire attach    = port_main_control[ulbv_pkg::MAIN_ATTACH_BIT];
  wire host_role = port_main_control[ulbv_pkg::MAIN_HOST_BIT];
  wire ovr       = otg_control[ulbv_pkg::OTG_OVR_BIT];
  wire dppu_ovr  = otg_control[ulbv_pkg::OTG_DPPU_BIT];
  wire dppd_ovr  = otg_control[ulbv_pkg::OTG_DPPD_BIT];
  wire dmpd_ovr  = otg_control[ulbv_pkg::OTG_DMPD_BIT];
  wire cnt_run   = boost_pwm_control[ulbv_pkg::PWMC_CNT_BIT];
  wire out_on    = boost_pwm_control[ulbv_pkg::PWMC_ON_BIT];
  wire out_pol   = boost_pwm_control[ulbv_pkg::PWMC_POL_BIT];
  wire [7:0] per  = boost_pwm_rate[ulbv_pkg::RATE_PER_LSB +: ulbv_pkg::RATE_W];
  wire [7:0] duty = boost_pwm_rate[ulbv_pkg::RATE_DUTY_LSB +: ulbv_pkg::RATE_W];

  // Pull selection; suspend bit deliberately has no term here so
  // entering suspend never drops the attach pull-up
  wire next_pu  = ovr ? dppu_ovr : (attach & ~host_role);
  wire next_dpd = ovr ? dppd_ovr : host_role;
  wire next_dmd = ovr ? dmpd_ovr : host_role;

  ////////////////////////////////////////////////////////////////////////
  // Registered line-bias and VBUS controls
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dp_pullup_o   <= 1'b0;
      dp_pulldown_o <= 1'b0;
      dm_pulldown_o <= 1'b0;
      vbus_gen_o    <= 1'b0;
      vbus_target_o <= 1'b0;
      vbus_dischg_o <= 1'b0;
    end
    else
    begin
      dp_pullup_o   <= next_pu;
      dp_pulldown_o <= next_dpd;
      dm_pulldown_o <= next_dmd;
      vbus_gen_o    <= otg_control[ulbv_pkg::OTG_GEN_BIT];
      vbus_target_o <= otg_control[ulbv_pkg::OTG_TARGET_BIT];
      vbus_dischg_o <= otg_control[ulbv_pkg::OTG_DISCHG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boost PWM; external comparators only reported, the supply limits itself
  ulbv_pwm #(
    .W (ulbv_pkg::RATE_W)
  ) u_pwm (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .run_i    (cnt_run),
    .on_i     (out_on),
    .pol_i    (out_pol),
    .period_i (per),
    .duty_i   (duty),
    .pwm_o    (boost_pwm_o),
    .count_o  (pwm_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux; status shows live block state
  wire [15:0] status_word = {6'h00, pwm_count, over_curr_i, vbus_ok_i};
  wire [15:0] rd_word =
      sel_main ? port_main_control  :
      sel_otg  ? otg_control        :
      sel_pwr  ? port_power_control :
      sel_rate ? boost_pwm_rate     :
      sel_pwmc ? boost_pwm_control  :
      sel_stat ? status_word        : 16'h0000;
  assign prdata_o = {16'h0000, rd_word};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ovr_on;
    ovr;
  endsequence

  a_pu_attach: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ovr && attach && !host_role |=> dp_pullup_o) else $error("pull-up not engaged");
  a_pu_override: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_ovr_on |=> dp_pullup_o == $past(dppu_ovr)) else $error("pull-up ignores override");
  a_pd_host: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ovr && host_role |=> dp_pulldown_o && dm_pulldown_o) else $error("pull-downs not paired");
  a_pd_override: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_ovr_on |=> dp_pulldown_o == $past(dppd_ovr) && dm_pulldown_o == $past(dmpd_ovr))
    else $error("pull-downs ignore override");
  a_pu_suspend: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dp_pullup_o && $stable(port_main_control & ~(16'h0001 << ulbv_pkg::MAIN_SUSP_BIT))
    && $stable(otg_control)
    |=> dp_pullup_o) else $error("pull-up dropped without control change");
  a_gen_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    otg_control[ulbv_pkg::OTG_GEN_BIT] [*2] |-> vbus_gen_o) else $error("vbus gen stuck");
  a_target_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 vbus_target_o == $past(otg_control[ulbv_pkg::OTG_TARGET_BIT]))
    else $error("target select not applied");
  a_rate_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr && sel_rate |=> per == $past(pwdata_i[7:0]) && duty == $past(pwdata_i[15:8]))
    else $error("rate fields misplaced");
endmodule
`default_nettype wire

// *** usb_line_bias_vbus_boost_ctl_bench.sv ***
`default_nettype none
module usb_line_bias_vbus_boost_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, fault = 1'b0, host_vbus = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, vok, ocur, dpu, dpd, dmd, pwm, gen, tgt, dis, e;
  int          n_fail = 0, check_count = 0, cyc = 0, h;

  always #10 clk_i = ~clk_i;

  ulbv_top i_ulbv_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .vbus_ok_i(vok), .over_curr_i(ocur),
    .dp_pullup_o(dpu), .dp_pulldown_o(dpd), .dm_pulldown_o(dmd), .boost_pwm_o(pwm),
    .vbus_gen_o(gen), .vbus_target_o(tgt), .vbus_dischg_o(dis));
  ulbv_supply_model i_ulbv_supply_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .pwm_i(pwm),
    .gen_i(gen), .fault_i(fault), .host_vbus_i(host_vbus), .vbus_ok_o(vok),
    .over_curr_o(ocur));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles; request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, then let the registered outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // High cycles of the drive over two whole periods of five
  task automatic hi();
    h = 0;
    repeat (10)
    begin
      @(posedge clk_i);
      #1;
      h += int'(pwm === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a <= 20; a += 4)
    begin
      xfer(1'b0, a[7:0], 32'h0);
      chk(r, 32'h0);
      chk({30'h0, pready, e}, 32'h2);
    end
    xfer(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Host powers the bus first; attach only once the comparator shows it
    host_vbus <= 1'b1;
    repeat (2) @(posedge clk_i);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, r[0]}, 32'h1);
    wr(8'h00, 32'hffff);
    xfer(1'b0, 8'h00, 32'h0);
    chk(r, 32'h000b);
    wr(8'h00, 32'h1);
    chk({dpu, dpd, dmd}, 3'b100);
    wr(8'h00, 32'h3);
    chk({dpu, dpd, dmd}, 3'b100);
    wr(8'h00, 32'h8);
    chk({dpu, dpd, dmd}, 3'b011);
    wr(8'h04, 32'h84);
    chk({dpu, dpd, dmd}, 3'b100);
    wr(8'h04, 32'ha4);
    chk({dpu, dpd, dmd}, 3'b110);
    wr(8'h04, 32'h94);
    chk({dpu, dpd, dmd}, 3'b101);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h04);
    chk({dpu, dpd, dmd}, 3'b000);
    wr(8'h04, 32'h01);
    chk({gen, tgt, dis}, 3'b001);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
    // Host lets go of the bus; the comparator must now read low
    @(posedge clk_i);
    host_vbus <= 1'b0;
    xfer(1'b0, 8'h14, 32'h0);
    chk({30'h0, r[1:0]}, 32'h0);
    // Software bring-up of bus power in the documented order
    wr(8'h08, 32'h1);
    xfer(1'b0, 8'h08, 32'h0);
    chk(r, 32'h1);
    xfer(1'b0, 8'h04, 32'h0);
    chk({31'h0, r[0]}, 32'h0);
    wr(8'h0c, 32'h0204);
    wr(8'h10, 32'h8000);
    hi();
    chk(h, 10);
    xfer(1'b0, 8'h14, 32'h0);
    chk({24'h0, r[9:2]}, 32'h0);
    wr(8'h10, 32'h8100);
    hi();
    chk(h, 4);
    wr(8'h10, 32'h8300);
    hi();
    chk(h, 6);
    wr(8'h10, 32'h0100);
    hi();
    chk(h, 0);
    wr(8'h10, 32'h8100);
    wr(8'h04, 32'h02);
    chk({gen, tgt, dis}, 3'b010);
    wr(8'h04, 32'h0a);
    chk({gen, tgt, dis}, 3'b110);
    repeat (20) @(posedge clk_i);
    fault <= 1'b1;
    repeat (2) @(posedge clk_i);
    xfer(1'b0, 8'h14, 32'h0);
    chk({30'h0, r[1:0]}, 32'h3);
    conclude();
  end
endmodule
`default_nettype wire
